/* File: include/fspr_defs.vh */
`ifndef FSPR_DEFS_VH
`define FSPR_DEFS_VH

// command opcodes
`define FSPR_OP_READ_STATUS 8'h05
`define FSPR_OP_READ_STATUS2 8'h07
`define FSPR_OP_ENABLE_NV 8'h06
`define FSPR_OP_ENABLE_VOL 8'h50
`define FSPR_OP_DISABLE 8'h04
`define FSPR_OP_WRITE_REGS 8'h01
`define FSPR_OP_WRITE_ANY 8'h71
`define FSPR_OP_READ_ANY 8'h65
`define FSPR_OP_CLEAR 8'h30
`define FSPR_OP_SUSPEND 8'h75
`define FSPR_OP_RESET_EN 8'h66
`define FSPR_OP_RESET 8'h99
`define FSPR_OP_PROGRAM 8'h02
`define FSPR_OP_ERASE_SECTOR 8'h20
`define FSPR_OP_ERASE_HALF 8'h52
`define FSPR_OP_ERASE_BLOCK 8'hd8
`define FSPR_OP_ERASE_CHIP 8'h60
`define FSPR_OP_ERASE_CHIP2 8'hc7

// status byte field positions
`define FSPR_BIT_PROT_EN 7
`define FSPR_BIT_SECTOR 6
`define FSPR_BIT_BOTTOM 5
`define FSPR_BP_HI 4
`define FSPR_BP_LO 2
`define FSPR_BIT_LATCH 1
`define FSPR_BIT_BUSY 0
`define FSPR_BIT_ERASE_ERR 6
`define FSPR_BIT_PROG_ERR 5

// register address seen by read-any / write-any
`define FSPR_ADDR_STATUS1 24'h000000

// fixed defaults of the latch and busy bits
`define FSPR_LATCH_DEFAULT 1'b0
`define FSPR_BUSY_DEFAULT 1'b0

// register write duration: 200 ns at 250 MHz, in clocks
`define FSPR_REG_WRITE_CYCLES 16'h0032

`endif

/* File: rtl/fspr_sync.v */
`timescale 1ns/1ps
`default_nettype none

module fspr_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // pins
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // first stage feeds only the second
  reg [WIDTH-1:0] stage_reg;

  always @(posedge clk_in) begin
    if (reset_in) begin
      stage_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/fspr_status.v */
// Functional notes
// [RULE1] Read-status-one command 05h returns the status byte.
// [RULE2] Protect enable set and write-protect low: status/config writes are ignored.
// [RULE3] Protect enable clear: no register protection regardless of write-protect pin.
// [RULE4] Write-protect pin affects only status and configuration register writes.
// [RULE5] Volatile protect enable follows every change of its non-volatile default; a register write in the same cycle overrides it.
// [RULE6] Quad command or quad io mode forces internal write-protect high.
// [RULE7] Bit 6 selects 64 KB blocks (0) or 4 KB sectors (1).
// [RULE8] Bit 5 selects protection from top (0) or from address zero (1).
// [RULE9] Volatile bottom bit follows every change of its non-volatile default; a register write in the same cycle overrides it.
// [RULE10] Bits 4 to 2 select the region where program and erase are refused.
// [RULE11] Protected region scales from one sixty-fourth up to the whole array.
// [RULE12] Program, register write or erase start only with the latch set.
// [RULE13] Non-volatile or volatile write-enable command sets the latch.
// [RULE14] Write-disable command clears the latch.
// [RULE15] Successful program, register write or erase clears the latch.
// [RULE16] Failed operation may leave the latch set; clear-status 30h clears it.
// [RULE17] Power-up, hardware or software reset load the latch from its default.
// [RULE18] Register writes leave latch and busy bits unchanged; both read-only.
// [RULE19] Busy bit is high during any embedded operation; new operations ignored.
// [RULE20] While busy only reads, suspend, clear-status and 66h/99h reset are taken.
// [RULE21] Suspend is accepted only while an array program or erase runs.
// [RULE22] Error flags update while busy; a set error keeps busy high.
// [RULE23] After an error only clear-status returns the device to standby; a 66h/99h software reset also does so here.
// [RULE24] Latch and busy defaults read 0 and cannot be written.
// [RULE25] Clear-status resets a set erase or program error flag.
// [RULE26] Status byte shifts out msb first, repeating while clocks continue.
`timescale 1ns/1ps
`default_nettype none
`include "fspr_defs.vh"

module fspr_status #(
  parameter [15:0] REG_WRITE_CYCLES = `FSPR_REG_WRITE_CYCLES
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // serial link pins
  input wire sclk_in,
  input wire cs_n_in,
  input wire mosi_in,
  output reg miso_out,
  output wire miso_oe_out,
  input wire wp_n_in,
  // non-volatile defaults and interface modes
  input wire reg_protect_default_in,
  input wire sector_default_in,
  input wire bottom_protect_default_in,
  input wire [2:0] block_protect_default_in,
  input wire quad_command_mode_in,
  input wire quad_io_mode_in,
  // array engine
  output reg op_start_out,
  output reg op_erase_out,
  output reg suspend_out,
  output reg sw_reset_out,
  input wire op_done_in,
  input wire op_fail_in,
  // status view
  output wire [7:0] status_out,
  output wire hw_protected_out,
  output wire erase_error_out,
  output wire program_error_out,
  output wire protect_sectors_out,
  output wire protect_bottom_out,
  output reg [6:0] protect_64ths_out
);

  localparam [4:0] ST_OPCODE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_WDATA = 5'h04;
  localparam [4:0] ST_READ = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;

  // protected size in 64ths of the array
  function [6:0] fspr_region_64ths;
    input [2:0] bp;
    begin
      case (bp)
        3'h0: fspr_region_64ths = 7'h00;
        3'h1: fspr_region_64ths = 7'h01;
        3'h2: fspr_region_64ths = 7'h02;
        3'h3: fspr_region_64ths = 7'h04;
        3'h4: fspr_region_64ths = 7'h08;
        3'h5: fspr_region_64ths = 7'h10;
        3'h6: fspr_region_64ths = 7'h20;
        default: fspr_region_64ths = 7'h40;
      endcase
    end
  endfunction

  function fspr_is_erase;
    input [7:0] op;
    begin
      fspr_is_erase = (op == `FSPR_OP_ERASE_SECTOR) || (op == `FSPR_OP_ERASE_HALF) ||
        (op == `FSPR_OP_ERASE_BLOCK) || (op == `FSPR_OP_ERASE_CHIP) || (op == `FSPR_OP_ERASE_CHIP2);
    end
  endfunction

  function fspr_busy_allowed;
    input [7:0] op;
    begin
      fspr_busy_allowed = (op == `FSPR_OP_READ_STATUS) || (op == `FSPR_OP_READ_STATUS2) ||
        (op == `FSPR_OP_READ_ANY) || (op == `FSPR_OP_SUSPEND) || (op == `FSPR_OP_CLEAR) ||
        (op == `FSPR_OP_RESET_EN) || (op == `FSPR_OP_RESET);
    end
  endfunction

  wire [3:0] pins_sync;
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  wire wp_n_s;

  fspr_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h5)
  ) u_pin_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in({sclk_in, cs_n_in, mosi_in, wp_n_in}),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[3];
  assign cs_n_s = pins_sync[2];
  assign mosi_s = pins_sync[1];
  assign wp_n_s = pins_sync[0];

  // link framing
  reg sclk_d_reg;
  reg cs_n_d_reg;
  reg [4:0] state_reg;
  reg [6:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg [1:0] addr_cnt_reg;
  reg [7:0] opcode_reg;
  reg [23:0] addr_reg;
  reg [7:0] data_reg;
  reg data_ok_reg;
  reg [2:0] out_cnt_reg;
  reg [6:0] tx_reg;

  // status and control
  reg prot_en_reg;
  reg sector_reg;
  reg bottom_reg;
  reg [2:0] bp_reg;
  reg latch_reg;
  reg busy_reg;
  reg erase_err_reg;
  reg prog_err_reg;
  reg array_active_reg;
  reg reg_write_active_reg;
  reg [15:0] wr_cnt_reg;
  reg reset_armed_reg;
  reg prev_prot_default_reg;
  reg prev_bottom_default_reg;

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire frame_on = ~cs_n_s;
  wire frame_end = cs_n_s & ~cs_n_d_reg;
  wire [7:0] rx_byte = {shift_reg, mosi_s};
  wire addr_hit = (addr_reg == `FSPR_ADDR_STATUS1);
  // a frame counts only with an opcode and no partial byte
  wire frame_valid = frame_end && (state_reg != ST_OPCODE) && (bit_cnt_reg == 3'h0);
  wire cmd_allowed = ~busy_reg | fspr_busy_allowed(opcode_reg); // [RULE19] [RULE20]

  // quad modes reuse the pin as data, so its level means nothing there
  wire wp_internal = wp_n_s | quad_command_mode_in | quad_io_mode_in; // [RULE6]
  wire hw_protected = prot_en_reg & ~wp_internal; // [RULE2] [RULE3]

  wire is_reg_write = (opcode_reg == `FSPR_OP_WRITE_REGS) ||
    ((opcode_reg == `FSPR_OP_WRITE_ANY) && addr_hit);
  // the pin only gates writes aimed at this register
  wire reg_write_ok = is_reg_write & data_ok_reg & ~hw_protected; // [RULE4]
  wire array_op = (opcode_reg == `FSPR_OP_PROGRAM) || fspr_is_erase(opcode_reg);

  assign status_out = {prot_en_reg, sector_reg, bottom_reg, bp_reg, latch_reg, busy_reg};
  assign hw_protected_out = hw_protected;
  assign erase_error_out = erase_err_reg;
  assign program_error_out = prog_err_reg;
  assign protect_sectors_out = sector_reg; // [RULE7]
  assign protect_bottom_out = bottom_reg; // [RULE8]
  assign miso_oe_out = frame_on & (state_reg == ST_READ);

  reg [7:0] read_value;

  always @* begin
    case (opcode_reg)
      `FSPR_OP_READ_STATUS: read_value = status_out; // [RULE1]
      `FSPR_OP_READ_STATUS2: read_value = {1'b0, erase_err_reg, prog_err_reg, 5'h00};
      `FSPR_OP_READ_ANY: read_value = addr_hit ? status_out : 8'h00;
      default: read_value = 8'h00;
    endcase
  end

  // serial framing: sample on rising sclk, drive on falling sclk
  always @(posedge clk_in) begin
    if (reset_in) begin
      // matches the idle-low synced sclk, so no false edge after reset
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
      state_reg <= ST_OPCODE;
      shift_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
      addr_cnt_reg <= 2'h0;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      data_reg <= 8'h00;
      data_ok_reg <= 1'b0;
      out_cnt_reg <= 3'h0;
      tx_reg <= 7'h00;
      miso_out <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
      if (~frame_on) begin
        state_reg <= ST_OPCODE;
        bit_cnt_reg <= 3'h0;
        addr_cnt_reg <= 2'h0;
        data_ok_reg <= 1'b0;
        out_cnt_reg <= 3'h0;
        miso_out <= 1'b0;
      end else if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        shift_reg <= rx_byte[6:0];
        if (bit_cnt_reg == 3'h7) begin
          case (state_reg)
            ST_OPCODE: begin
              opcode_reg <= rx_byte;
              if (rx_byte == `FSPR_OP_READ_STATUS || rx_byte == `FSPR_OP_READ_STATUS2) begin
                state_reg <= ST_READ;
              end else if (rx_byte == `FSPR_OP_READ_ANY || rx_byte == `FSPR_OP_WRITE_ANY) begin
                state_reg <= ST_ADDR;
              end else if (rx_byte == `FSPR_OP_WRITE_REGS) begin
                state_reg <= ST_WDATA;
              end else begin
                state_reg <= ST_SKIP;
              end
            end
            ST_ADDR: begin
              addr_reg <= {addr_reg[15:0], rx_byte};
              addr_cnt_reg <= addr_cnt_reg + 2'h1;
              if (addr_cnt_reg == 2'h2) begin
                state_reg <= (opcode_reg == `FSPR_OP_READ_ANY) ? ST_READ : ST_WDATA;
              end
            end
            ST_WDATA: begin
              // further bytes belong to other registers
              data_reg <= rx_byte;
              data_ok_reg <= 1'b1;
              state_reg <= ST_SKIP;
            end
            ST_READ: begin
              state_reg <= ST_READ;
            end
            ST_SKIP: begin
              state_reg <= ST_SKIP;
            end
            default: begin
              state_reg <= ST_SKIP;
            end
          endcase
        end
      end else if (sclk_fall && state_reg == ST_READ) begin
        // byte is re-sampled at each boundary so busy changes show
        out_cnt_reg <= out_cnt_reg + 3'h1;
        if (out_cnt_reg == 3'h0) begin
          miso_out <= read_value[7]; // [RULE26]
          tx_reg <= read_value[6:0];
        end else begin
          miso_out <= tx_reg[6]; // [RULE26]
          tx_reg <= {tx_reg[5:0], 1'b0};
        end
      end
    end
  end

  task fspr_load_defaults;
    begin
      prot_en_reg <= reg_protect_default_in;
      sector_reg <= sector_default_in;
      bottom_reg <= bottom_protect_default_in;
      bp_reg <= block_protect_default_in;
      latch_reg <= `FSPR_LATCH_DEFAULT; // [RULE17] [RULE24]
      busy_reg <= `FSPR_BUSY_DEFAULT; // [RULE24]
      erase_err_reg <= 1'b0;
      prog_err_reg <= 1'b0;
      array_active_reg <= 1'b0;
      reg_write_active_reg <= 1'b0;
      wr_cnt_reg <= 16'h0000;
    end
  endtask

  // status bits; later assignments win, so sets follow clears
  always @(posedge clk_in) begin
    op_start_out <= 1'b0;
    suspend_out <= 1'b0;
    sw_reset_out <= 1'b0;
    if (reset_in) begin
      fspr_load_defaults;
      op_erase_out <= 1'b0;
      reset_armed_reg <= 1'b0;
      prev_prot_default_reg <= 1'b0;
      prev_bottom_default_reg <= 1'b0;
      protect_64ths_out <= 7'h00;
    end else begin
      protect_64ths_out <= fspr_region_64ths(bp_reg); // [RULE10] [RULE11]
      prev_prot_default_reg <= reg_protect_default_in;
      prev_bottom_default_reg <= bottom_protect_default_in;
      if (reg_protect_default_in != prev_prot_default_reg) begin
        prot_en_reg <= reg_protect_default_in; // [RULE5]
      end
      if (bottom_protect_default_in != prev_bottom_default_reg) begin
        bottom_reg <= bottom_protect_default_in; // [RULE9]
      end

      // completion of register write
      if (reg_write_active_reg) begin
        if (wr_cnt_reg == 16'h0001) begin
          reg_write_active_reg <= 1'b0;
          busy_reg <= 1'b0;
          latch_reg <= 1'b0; // [RULE15]
        end else begin
          wr_cnt_reg <= wr_cnt_reg - 16'h0001;
        end
      end

      // completion of array operation; on failure latch and busy stay
      if (array_active_reg && op_done_in) begin
        array_active_reg <= 1'b0;
        if (~op_fail_in) begin
          busy_reg <= 1'b0;
          latch_reg <= 1'b0; // [RULE15]
        end
      end

      if (frame_end && state_reg != ST_OPCODE) begin
        reset_armed_reg <= frame_valid && (opcode_reg == `FSPR_OP_RESET_EN);
      end

      if (frame_valid && cmd_allowed) begin
        case (opcode_reg)
          `FSPR_OP_ENABLE_NV, `FSPR_OP_ENABLE_VOL: begin
            latch_reg <= 1'b1; // [RULE13]
          end
          `FSPR_OP_DISABLE: begin
            latch_reg <= 1'b0; // [RULE14]
          end
          `FSPR_OP_CLEAR: begin
            latch_reg <= 1'b0; // [RULE16]
            erase_err_reg <= 1'b0; // [RULE25]
            prog_err_reg <= 1'b0; // [RULE25]
            if ((erase_err_reg | prog_err_reg) && ~array_active_reg && ~reg_write_active_reg) begin
              busy_reg <= 1'b0; // [RULE23]
            end
          end
          `FSPR_OP_SUSPEND: begin
            if (array_active_reg) begin
              suspend_out <= 1'b1; // [RULE21]
            end
          end
          `FSPR_OP_RESET: begin
            if (reset_armed_reg) begin
              fspr_load_defaults; // [RULE17]
              sw_reset_out <= 1'b1;
            end
          end
          default: begin
            // write data never reaches latch or busy
            if (is_reg_write && latch_reg && reg_write_ok) begin // [RULE12] [RULE2]
              prot_en_reg <= data_reg[`FSPR_BIT_PROT_EN]; // [RULE18]
              sector_reg <= data_reg[`FSPR_BIT_SECTOR];
              bottom_reg <= data_reg[`FSPR_BIT_BOTTOM];
              bp_reg <= data_reg[`FSPR_BP_HI:`FSPR_BP_LO];
              busy_reg <= 1'b1; // [RULE19]
              reg_write_active_reg <= 1'b1;
              wr_cnt_reg <= REG_WRITE_CYCLES;
            end else if (array_op && latch_reg) begin // [RULE12]
              op_start_out <= 1'b1;
              op_erase_out <= fspr_is_erase(opcode_reg);
              busy_reg <= 1'b1; // [RULE19]
              array_active_reg <= 1'b1;
            end
          end
        endcase
      end

      // error set wins over a clear in the same cycle
      if (array_active_reg && op_done_in && op_fail_in) begin
        if (op_erase_out) begin
          erase_err_reg <= 1'b1; // [RULE22]
        end else begin
          prog_err_reg <= 1'b1; // [RULE22]
        end
        busy_reg <= 1'b1; // [RULE22]
      end
    end
  end

endmodule

`default_nettype wire

/* File: sim/fspr_status_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fspr_status_props #(
  parameter [15:0] REG_WRITE_CYCLES = 16'h0032
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // defaults, modes and array engine
  input wire logic reg_protect_default_in,
  input wire logic bottom_protect_default_in,
  input wire logic quad_command_mode_in,
  input wire logic quad_io_mode_in,
  input wire logic op_done_in,
  input wire logic op_fail_in,
  // watched outputs
  input wire logic op_start_out,
  input wire logic op_erase_out,
  input wire logic sw_reset_out,
  input wire logic [7:0] status_out,
  input wire logic hw_protected_out,
  input wire logic erase_error_out,
  input wire logic program_error_out,
  input wire logic [6:0] protect_64ths_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic act_reg;
  logic [1:0] def_reg;
  wire err_any = erase_error_out | program_error_out;
  wire quiet = def_reg == {reg_protect_default_in, bottom_protect_default_in};
  // array op in flight; a software reset abandons it
  always_ff @(posedge clk_in) begin
    def_reg <= {reg_protect_default_in, bottom_protect_default_in};
    if (reset_in || sw_reset_out || op_done_in) act_reg <= 1'b0;
    else if (op_start_out) act_reg <= 1'b1;
  end
  function automatic logic [6:0] size64(input logic [2:0] bp);
    return (bp == 3'h0) ? 7'h00 : 7'h01 << (bp - 3'h1);
  endfunction
  sequence s_ok_done;
    act_reg && op_done_in && !op_fail_in;
  endsequence
  sequence s_bad_done;
    act_reg && op_done_in && op_fail_in;
  endsequence
  sequence s_locked;
    hw_protected_out && quiet && !sw_reset_out ##1 quiet && !sw_reset_out;
  endsequence
  start_a: assert property (op_start_out |-> status_out[1] && !$past(status_out[0]) ##1 status_out[0])
    else $error("bad array op start");
  ok_done_a: assert property (s_ok_done |=> status_out[1:0] == 2'b00)
    else $error("latch or busy kept");
  bad_done_a: assert property (s_bad_done |=> status_out[0] && (op_erase_out ? erase_error_out : program_error_out)
    ##1 status_out[0])
    else $error("failure not held");
  err_busy_a: assert property ($rose(err_any) |-> status_out[0])
    else $error("error without busy");
  unprot_a: assert property (quad_command_mode_in || quad_io_mode_in || !status_out[7] |-> !hw_protected_out)
    else $error("protection not lifted");
  locked_a: assert property (s_locked |-> $stable(status_out[7:2]))
    else $error("locked bits changed");
  track_a: assert property (def_reg[1] != reg_protect_default_in |=> status_out[7] == def_reg[1])
    else $error("default not followed");
  bottom_track_a: assert property (def_reg[0] != bottom_protect_default_in |=> status_out[5] == def_reg[0])
    else $error("bottom default not followed");
  size_a: assert property (!$past(reset_in) |-> protect_64ths_out == size64($past(status_out[4:2])))
    else $error("protected size wrong");
  swr_a: assert property (sw_reset_out |-> ##[0:1] status_out[1:0] == 2'b00)
    else $error("latch after reset");
endmodule
bind fspr_status fspr_status_props #(.REG_WRITE_CYCLES(REG_WRITE_CYCLES)) i_fspr_status_props (
  .clk_in(clk_in), .reset_in(reset_in), .reg_protect_default_in(reg_protect_default_in),
  .bottom_protect_default_in(bottom_protect_default_in), .quad_command_mode_in(quad_command_mode_in),
  .quad_io_mode_in(quad_io_mode_in), .op_done_in(op_done_in), .op_fail_in(op_fail_in),
  .op_start_out(op_start_out), .op_erase_out(op_erase_out), .sw_reset_out(sw_reset_out),
  .status_out(status_out), .hw_protected_out(hw_protected_out), .erase_error_out(erase_error_out),
  .program_error_out(program_error_out), .protect_64ths_out(protect_64ths_out));
`default_nettype wire

/* File: sim/fspr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fspr_host (
  // serial link
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // opcode, n-1 zero bytes, then dat; rd keeps the last byte shifted in
  task automatic frame(input logic [7:0] op, input int n, input logic [7:0] dat, output logic [7:0] rd);
    logic [7:0] tx;
    cs_n_out = 1'b0;
    for (int k = 0; k <= n; k++) begin
      tx = (k == 0) ? op : (k == n) ? dat : 8'h00;
      for (int i = 7; i >= 0; i--) begin
        mosi_out = tx[i];
        #62.5 sclk_out = 1'b1;
        rd[i] = miso_in;
        #62.5 sclk_out = 1'b0;
      end
    end
    #62.5 cs_n_out = 1'b1;
    // no pull on the line: never leave the last bit showing
    mosi_out = ~mosi_out;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: sim/fspr_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fspr_status_tb;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wp_n = 1'b1, qc = 1'b0, qi = 1'b0, done_p = 1'b0, fail_p = 1'b0;
  logic pd = 1'b0, sd = 1'b1, bd = 1'b0;
  logic [2:0] bpd = 3'h5;
  wire sclk, cs_n, mosi, miso, oe, start, erase, susp, swr, hwp, e_err, p_err, ps, pb;
  wire [7:0] status;
  wire [6:0] p64;
  wire miso_line = oe ? miso : ~miso;
  logic [7:0] rd, exp_s, n_st, starts = 8'h00, susps = 8'h00, resets = 8'h00;
  logic [31:0] seed = 32'h0000426a;
  logic [7:0] ops [6] = '{8'h20, 8'h02, 8'h52, 8'hd8, 8'h60, 8'hc7};
  // {wp_n, quad cmd, quad io, write-any, data}
  logic [11:0] wt [5] = '{12'h89c, 12'h100, 12'h280, 12'h560, 12'h004};
  int err_total = 0, cmp_count = 0;
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (start === 1'b1) starts <= starts + 8'h01;
    if (susp === 1'b1) susps <= susps + 8'h01;
    if (swr === 1'b1) resets <= resets + 8'h01;
  end
  fspr_host i_fspr_host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso_line));
  fspr_status #(.REG_WRITE_CYCLES(16'h0050)) i_fspr_status (
    .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_out(oe), .wp_n_in(wp_n), .reg_protect_default_in(pd),
    .sector_default_in(sd), .bottom_protect_default_in(bd), .block_protect_default_in(bpd),
    .quad_command_mode_in(qc), .quad_io_mode_in(qi), .op_start_out(start), .op_erase_out(erase),
    .suspend_out(susp), .sw_reset_out(swr), .op_done_in(done_p), .op_fail_in(fail_p),
    .status_out(status), .hw_protected_out(hwp), .erase_error_out(e_err), .program_error_out(p_err),
    .protect_sectors_out(ps), .protect_bottom_out(pb), .protect_64ths_out(p64));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [6:0] exp64(input logic [2:0] bp);
    return (bp == 3'h0) ? 7'h00 : 7'h01 << (bp - 3'h1);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] d);
    i_fspr_host.frame(op, n, d, rd);
    // realign so checks never sample on a clock edge
    tick();
  endtask
  task automatic idle();
    int w;
    w = 0;
    while (status[0] !== 1'b0 && w < 500) begin
      tick();
      w++;
    end
    check(w < 500, 1'b1);
  endtask
  task automatic done(input logic f);
    tick();
    done_p = 1'b1;
    fail_p = f;
    tick();
    done_p = 1'b0;
    fail_p = 1'b0;
    repeat (2) tick();
  endtask
  task automatic wr(input logic [11:0] c);
    logic p;
    tick();
    {wp_n, qc, qi} = c[11:9];
    repeat (4) tick();
    cmd(c[8] ? 8'h50 : 8'h06, 0, 8'h00);
    check(status[1], 1'b1);
    p = exp_s[7] & ~wp_n & ~qc & ~qi;
    check(hwp, p);
    cmd(c[8] ? 8'h71 : 8'h01, c[8] ? 4 : 1, c[7:0]);
    check(status[1:0], {1'b1, ~p});
    idle();
    if (!p) exp_s[7:2] = c[7:2];
    exp_s[1] = p;
    check(status, exp_s);
    check({ps, pb, p64}, {exp_s[6:5], exp64(exp_s[4:2])});
    cmd(8'h04, 0, 8'h00);
    exp_s[1] = 1'b0;
    check(status[1], 1'b0);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400us;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (4) tick();
    reset_in = 1'b0;
    repeat (4) tick();
    exp_s = {pd, sd, bd, bpd, 2'b00};
    check(status, exp_s);
    cmd(8'h05, 2, 8'h00);
    check(rd, exp_s);
    cmd(8'h65, 4, 8'h00);
    check(rd, exp_s);
    cmd(8'h01, 1, 8'hff);
    check(status, exp_s);
    for (int i = 0; i < 13; i++) begin
      seed = xs(seed);
      wr(i < 5 ? wt[i] : seed[11:0]);
    end
    wr(12'h280);
    tick();
    qi = 1'b0;
    cmd(8'h02, 3, 8'h00);
    check(starts, 8'h00);
    cmd(8'h06, 0, 8'h00);
    cmd(8'h02, 3, 8'h00);
    check({hwp, starts}, 9'h101);
    cmd(8'h04, 0, 8'h00);
    cmd(8'h02, 3, 8'h00);
    cmd(8'h05, 1, 8'h00);
    check(rd, exp_s | 8'h03);
    check(starts, 8'h01);
    cmd(8'h75, 0, 8'h00);
    check(susps, 8'h01);
    done(1'b0);
    check(status[1:0], 2'b00);
    cmd(8'h75, 0, 8'h00);
    check(susps, 8'h01);
    n_st = 8'h01;
    foreach (ops[k]) begin
      cmd(8'h50, 0, 8'h00);
      cmd(ops[k], 3, 8'h00);
      n_st++;
      check({erase, starts}, {ops[k] != 8'h02, n_st});
      check(status[1:0], 2'b11);
      done(k[0]);
      if (k[0]) begin
        check({e_err, p_err, status[1:0]}, {ops[k] != 8'h02, ops[k] == 8'h02, 2'b11});
        cmd(8'h07, 1, 8'h00);
        check(rd, {1'b0, ops[k] != 8'h02, ops[k] == 8'h02, 5'h00});
        cmd(8'h02, 3, 8'h00);
        check(starts, n_st);
        cmd(8'h30, 0, 8'h00);
      end
      check({e_err, p_err, status[1:0]}, 4'h0);
    end
    tick();
    wp_n = 1'b1;
    cmd(8'h06, 0, 8'h00);
    cmd(8'h02, 3, 8'h00);
    cmd(8'h66, 0, 8'h00);
    cmd(8'h05, 0, 8'h00);
    cmd(8'h99, 0, 8'h00);
    check(resets, 8'h00);
    cmd(8'h66, 0, 8'h00);
    cmd(8'h99, 0, 8'h00);
    exp_s = {pd, sd, bd, bpd, 2'b00};
    check({resets, status}, {8'h01, exp_s});
    tick();
    pd = ~pd;
    bd = ~bd;
    repeat (4) tick();
    check({status[7], status[5]}, {pd, bd});
    finish_test();
  end
endmodule
`default_nettype wire
